//--- src/io_map_pkg.sv
// Purpose: Shared constants and carriers for the pulse-train and analog I/O map
// Assumes: 100 MHz control clock; settings in fixed point, 4096 counts = 100 %
// Notes: Parameter structs mirror the drive's configuration parameters
package io_map_pkg;
   // Clock and timing
   localparam int CLK_HZ = 100_000_000;
   localparam int GATE_MS = 100;
   localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;
   localparam int GATES_PER_SEC = 1000 / GATE_MS;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   // Setting scale
   localparam logic [15:0] PCT100 = 16'h1000;
   localparam logic [15:0] PCT300 = 16'h3000;
   localparam int FRAC_BITS = 12;
   // Analog input routing
   localparam int ROUTE_COUNT = 11;
   localparam int TORQUE_ROUTE_INDEX = 6;
   localparam logic [1:0] CH_NONE = 2'h0;
   localparam logic [1:0] CH_FIRST = 2'h1;
   localparam logic [1:0] CH_SECOND = 2'h2;
   localparam logic [1:0] CH_BIPOLAR = 2'h3;
   // Pulse input destination code
   localparam logic [2:0] SRC_PULSE = 3'h5;
   localparam int FILT_FRAC = 8;
   localparam int DIV_STEPS = 26;
   // Analog output
   localparam logic [1:0] OUT_MODE_VOLT = 2'h1;
   localparam logic [1:0] OUT_MODE_CURR = 2'h3;
   localparam int AOUT_MAX = 1023;
   localparam int CUR_BASE = 205;
   localparam int CUR_SPAN_MUL = 819;
   localparam int GAIN_SHIFT = 10;
   // Pulse output
   localparam logic [1:0] PULSE_OUT_ON = 2'h1;
   localparam logic [1:0] MAGNITUDE_ON = 2'h1;
   localparam logic [16:0] PULSE_MAX_X10 = 17'h186a0;
   localparam logic [29:0] NCO_HALF = 30'h1dcd6500;
   localparam int DATA_COUNT = 16;

   typedef struct packed {
      logic [11:0] first;
      logic [11:0] second;
      logic signed [11:0] bipolar;
      logic first_half;
      logic second_half;
   } analog_in_type;

   typedef struct packed {
      logic [2:0] speed_source_select;
      logic [2:0] traverse_source_select;
      logic [2:0] torque_source_select;
      logic [13:0] pulse_low_endpoint;
      logic [13:0] pulse_high_endpoint;
      logic [2:0] pulse_filter_time_constant;
      logic [15:0] pulse_loss_timeout;
   } pulse_in_cfg_type;

   typedef struct packed {
      logic [1:0] range_mode;
      logic [3:0] source;
      logic [9:0] gain;
      logic signed [10:0] voltage_offset;
      logic signed [10:0] current_offset;
   } analog_out_cfg_type;

   typedef struct packed {
      logic [1:0] enable;
      logic [3:0] source;
      logic [13:0] scale_first;
      logic [13:0] scale_second;
      logic [1:0] magnitude_select;
   } pulse_out_cfg_type;

   typedef enum logic {DIV_IDLE, DIV_RUN} div_state_type;
endpackage

//--- src/pulse_train_and_analog_io_map.sv
// Purpose: Analog input routing, pulse-train input scaling, analog and pulse outputs
// Assumes: All pins synchronous to i_clk; parameters held stable while in use
// Notes: Pulse frequency measured over fixed gates; filter constant is a shift exponent
`timescale 1ns/1ps
module pulse_train_and_analog_io_map #(
   parameter int GATE_LEN = io_map_pkg::GATE_CYCLES,
   parameter int MS_LEN = io_map_pkg::MS_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire io_map_pkg::analog_in_type i_analog_in,
   input wire logic [io_map_pkg::ROUTE_COUNT-1:0][1:0] i_analog_route_params,
   output logic [io_map_pkg::ROUTE_COUNT-1:0][15:0] o_settings,
   input wire logic i_pulse_input_terminal,
   output logic o_seq_in7,
   input wire io_map_pkg::pulse_in_cfg_type i_pulse_cfg,
   output logic [15:0] o_speed_pulse,
   output logic [15:0] o_traverse_pulse,
   output logic [15:0] o_torque_pulse,
   output logic o_pulse_off,
   input wire logic [io_map_pkg::DATA_COUNT-1:0][15:0] i_internal_data,
   input wire io_map_pkg::analog_out_cfg_type i_out_first_cfg,
   input wire io_map_pkg::analog_out_cfg_type i_out_second_cfg,
   output logic [9:0] o_analog_out_first,
   output logic [9:0] o_analog_out_second,
   output logic o_out_first_current,
   output logic o_out_second_current,
   input wire io_map_pkg::pulse_out_cfg_type i_pulse_out_cfg,
   input wire logic i_seq_out3,
   output logic o_pulse_output_terminal,
   output logic o_encoder_division_block
);

   // Raw channel to setting counts; half range drops the top bit and doubles the code
   function automatic logic [15:0] channel_value(input logic [1:0] sel,
                                                 input io_map_pkg::analog_in_type ain);
      logic [15:0] v;
      v = 16'h0000;
      unique case (sel)
         io_map_pkg::CH_NONE: v = 16'h0000;
         io_map_pkg::CH_FIRST: v = ain.first_half ? {4'h0, ain.first[10:0], 1'b0} :
                                   {4'h0, ain.first};
         io_map_pkg::CH_SECOND: v = ain.second_half ? {4'h0, ain.second[10:0], 1'b0} :
                                    {4'h0, ain.second};
         io_map_pkg::CH_BIPOLAR: v = {{3{ain.bipolar[11]}}, ain.bipolar, 1'b0};
      endcase
      return v;
   endfunction

   // Data times gain plus offset, clamped to the 10-bit output span
   function automatic logic [9:0] aout_code(input io_map_pkg::analog_out_cfg_type cfg,
                                            input logic [15:0] data);
      int scaled;
      int sum;
      scaled = ($signed(data) * int'(cfg.gain)) >>> io_map_pkg::GAIN_SHIFT;
      sum = 0;
      if (cfg.range_mode == io_map_pkg::OUT_MODE_VOLT)
         sum = scaled + int'(cfg.voltage_offset);
      else if (cfg.range_mode == io_map_pkg::OUT_MODE_CURR)
         sum = io_map_pkg::CUR_BASE + ((scaled * io_map_pkg::CUR_SPAN_MUL) >>> 10)
               + int'(cfg.current_offset);
      if (sum < 0)
         sum = 0;
      else if (sum > io_map_pkg::AOUT_MAX)
         sum = io_map_pkg::AOUT_MAX;
      return sum[9:0];
   endfunction

   // Analog input routing
   logic [io_map_pkg::ROUTE_COUNT-1:0][15:0] settings_next;
   genvar gi;
   generate
      for (gi = 0; gi < io_map_pkg::ROUTE_COUNT; gi++)
      begin : g_route
         wire logic [15:0] raw_value = channel_value(i_analog_route_params[gi], i_analog_in);
         if (gi == io_map_pkg::TORQUE_ROUTE_INDEX)
         begin : g_torque
            // Torque route scales first-channel input to three times the normal span
            assign settings_next[gi] = (i_analog_route_params[gi] == io_map_pkg::CH_FIRST) ?
                                       16'(raw_value * 16'h0003) : raw_value;
         end
         else
         begin : g_plain
            assign settings_next[gi] = raw_value;
         end
      end
   endgenerate

   // Register routed settings
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_settings <= '0;
      else
         o_settings <= settings_next;
   end

   // Pulse input use decode
   wire logic sel_speed = (i_pulse_cfg.speed_source_select == io_map_pkg::SRC_PULSE);
   wire logic sel_traverse = (i_pulse_cfg.traverse_source_select == io_map_pkg::SRC_PULSE);
   wire logic sel_torque = (i_pulse_cfg.torque_source_select == io_map_pkg::SRC_PULSE);
   wire logic pulse_in_used = sel_speed | sel_traverse | sel_torque;
   assign o_seq_in7 = pulse_in_used ? 1'b0 : i_pulse_input_terminal;

   // Edge detection and gate timing
   logic pin_reg;
   logic [31:0] gate_reg;
   logic [10:0] edge_count_reg;
   logic [31:0] ms_reg;
   logic [15:0] silence_reg;
   logic lost_reg;
   wire logic rise = i_pulse_input_terminal & ~pin_reg;
   wire logic gate_end = (gate_reg == 32'(GATE_LEN - 1));
   wire logic ms_tick = (ms_reg == 32'(MS_LEN - 1));
   wire logic [13:0] freq_raw = 14'(edge_count_reg * 11'(io_map_pkg::GATES_PER_SEC));
   wire logic silence_full = (i_pulse_cfg.pulse_loss_timeout != 16'h0000) &&
                             (silence_reg >= i_pulse_cfg.pulse_loss_timeout);

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pin_reg <= 1'b0;
         gate_reg <= 32'h0000_0000;
         edge_count_reg <= 11'h000;
      end
      else
      begin
         pin_reg <= i_pulse_input_terminal;
         gate_reg <= gate_end ? 32'h0000_0000 : gate_reg + 32'h0000_0001;
         if (gate_end)
            edge_count_reg <= {10'h000, rise};
         else if (rise && edge_count_reg != 11'h7ff)
            edge_count_reg <= edge_count_reg + 11'h001;
      end
   end

   // Pulse loss timer in milliseconds since the last edge
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ms_reg <= 32'h0000_0000;
         silence_reg <= 16'h0000;
         lost_reg <= 1'b1;
      end
      else
      begin
         ms_reg <= (ms_tick || rise) ? 32'h0000_0000 : ms_reg + 32'h0000_0001;
         if (rise)
            silence_reg <= 16'h0000;
         else if (ms_tick && silence_reg != 16'hffff)
            silence_reg <= silence_reg + 16'h0001;
         if (rise)
            lost_reg <= 1'b0;
         else if (silence_full)
            lost_reg <= 1'b1;
      end
   end

   // First-order low-pass on the detected frequency, updated once per gate
   logic [21:0] filt_reg;
   wire logic [21:0] raw_fixed = {freq_raw, 8'h00};
   wire logic signed [22:0] filt_err = $signed({1'b0, raw_fixed}) - $signed({1'b0, filt_reg});
   wire logic [21:0] filt_step = 22'(filt_err >>> i_pulse_cfg.pulse_filter_time_constant);
   wire logic [21:0] filt_next = (i_pulse_cfg.pulse_filter_time_constant == 3'h0) ?
                                 raw_fixed : filt_reg + filt_step;

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         filt_reg <= 22'h000000;
      else if (lost_reg)
         filt_reg <= 22'h000000;
      else if (gate_end)
         filt_reg <= filt_next;
   end

   // Endpoint clamping ahead of the divider
   wire logic [13:0] freq_filt = filt_reg[21:io_map_pkg::FILT_FRAC];
   wire logic [13:0] f_low = i_pulse_cfg.pulse_low_endpoint;
   wire logic [13:0] f_high = i_pulse_cfg.pulse_high_endpoint;
   wire logic below_low = (freq_filt <= f_low) || (f_high <= f_low);
   wire logic above_high = (freq_filt >= f_high);
   wire logic [13:0] div_den = f_high - f_low;
   wire logic [25:0] div_start = {freq_filt - f_low, 12'h000};

   // Serial restoring divider for the linear map
   io_map_pkg::div_state_type div_state_reg;
   logic [25:0] div_num_reg;
   logic [14:0] div_rem_reg;
   logic [4:0] div_count_reg;
   logic start_reg;
   logic [12:0] map_reg;
   wire logic [14:0] rem_shift = {div_rem_reg[13:0], div_num_reg[25]};
   wire logic rem_fits = (rem_shift >= {1'b0, div_den});
   wire logic div_last = (div_count_reg == 5'(io_map_pkg::DIV_STEPS - 1));

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         div_state_reg <= io_map_pkg::DIV_IDLE;
         div_num_reg <= 26'h0000000;
         div_rem_reg <= 15'h0000;
         div_count_reg <= 5'h00;
         start_reg <= 1'b0;
         map_reg <= 13'h0000;
      end
      else
      begin
         start_reg <= gate_end;
         unique case (div_state_reg)
            io_map_pkg::DIV_IDLE:
            begin
               if (start_reg && below_low)
                  map_reg <= 13'h0000;
               else if (start_reg && above_high)
                  map_reg <= io_map_pkg::PCT100[12:0];
               else if (start_reg)
               begin
                  div_num_reg <= div_start;
                  div_rem_reg <= 15'h0000;
                  div_count_reg <= 5'h00;
                  div_state_reg <= io_map_pkg::DIV_RUN;
               end
            end
            io_map_pkg::DIV_RUN:
            begin
               div_rem_reg <= rem_fits ? rem_shift - {1'b0, div_den} : rem_shift;
               div_num_reg <= {div_num_reg[24:0], rem_fits};
               div_count_reg <= div_count_reg + 5'h01;
               if (div_last)
               begin
                  map_reg <= {div_num_reg[11:0], rem_fits};
                  div_state_reg <= io_map_pkg::DIV_IDLE;
               end
            end
         endcase
      end
   end

   // Destination values; torque triples the span and never exceeds 300 percent
   wire logic [15:0] map_pct100 = {3'h0, map_reg};
   wire logic [15:0] map_pct300 = 16'(map_pct100 * 16'h0003);

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_speed_pulse <= 16'h0000;
         o_traverse_pulse <= 16'h0000;
         o_torque_pulse <= 16'h0000;
         o_pulse_off <= 1'b1;
      end
      else
      begin
         o_speed_pulse <= (sel_speed && !lost_reg) ? map_pct100 : 16'h0000;
         o_traverse_pulse <= (sel_traverse && !lost_reg) ? map_pct100 : 16'h0000;
         o_torque_pulse <= (sel_torque && !lost_reg) ? map_pct300 : 16'h0000;
         o_pulse_off <= lost_reg;
      end
   end

   // Analog outputs
   wire logic [9:0] aout_first_next =
      aout_code(i_out_first_cfg, i_internal_data[i_out_first_cfg.source]);
   wire logic [9:0] aout_second_next =
      aout_code(i_out_second_cfg, i_internal_data[i_out_second_cfg.source]);

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_analog_out_first <= 10'h000;
         o_analog_out_second <= 10'h000;
         o_out_first_current <= 1'b0;
         o_out_second_current <= 1'b0;
      end
      else
      begin
         o_analog_out_first <= aout_first_next;
         o_analog_out_second <= aout_second_next;
         o_out_first_current <=
            (i_out_first_cfg.range_mode == io_map_pkg::OUT_MODE_CURR);
         o_out_second_current <=
            (i_out_second_cfg.range_mode == io_map_pkg::OUT_MODE_CURR);
      end
   end

   // Pulse output frequency demand in tenths of a hertz
   wire logic pulse_out_on = (i_pulse_out_cfg.enable == io_map_pkg::PULSE_OUT_ON);
   wire logic [15:0] pout_data = i_internal_data[i_pulse_out_cfg.source];
   wire logic pout_negative = pout_data[15];
   wire logic [15:0] pout_mag = pout_negative ? 16'(-pout_data) : pout_data;
   wire logic mag_on = (i_pulse_out_cfg.magnitude_select == io_map_pkg::MAGNITUDE_ON);
   wire logic [13:0] pout_scale = pout_negative ? i_pulse_out_cfg.scale_second :
                                  i_pulse_out_cfg.scale_first;
   wire logic [33:0] pout_prod = 34'(pout_mag * pout_scale * 34'h000000000a);
   wire logic [21:0] pout_x10 = pout_prod[33:io_map_pkg::FRAC_BITS];
   wire logic [16:0] pout_capped = (pout_x10 > {5'h00, io_map_pkg::PULSE_MAX_X10}) ?
                                   io_map_pkg::PULSE_MAX_X10 : pout_x10[16:0];
   wire logic [16:0] pout_next = (!pulse_out_on || (pout_negative && !mag_on)) ?
                                 17'h00000 : pout_capped;

   // Phase accumulator toggles the pulse every half period
   logic [16:0] pout_freq_reg;
   logic [29:0] nco_reg;
   logic pulse_reg;
   wire logic [29:0] nco_sum = nco_reg + {13'h0000, pout_freq_reg};
   wire logic nco_wrap = (nco_sum >= io_map_pkg::NCO_HALF);

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pout_freq_reg <= 17'h00000;
         nco_reg <= 30'h00000000;
         pulse_reg <= 1'b0;
      end
      else
      begin
         pout_freq_reg <= pout_next;
         if (pout_freq_reg == 17'h00000)
         begin
            nco_reg <= 30'h00000000;
            pulse_reg <= 1'b0;
         end
         else
         begin
            nco_reg <= nco_wrap ? nco_sum - io_map_pkg::NCO_HALF : nco_sum;
            pulse_reg <= nco_wrap ? ~pulse_reg : pulse_reg;
         end
      end
   end

   // Terminal three carries pulses while enabled and locks out encoder division
   assign o_pulse_output_terminal = pulse_out_on ? pulse_reg : i_seq_out3;
   assign o_encoder_division_block = pulse_out_on;

endmodule

//--- dv/io_map_chk.sv
// Purpose: Port-level assertions for the pulse-train and analog I/O map
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to the design top from the testbench top file
`timescale 1ns/1ps
module io_map_chk (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire io_map_pkg::analog_in_type i_analog_in,
   input wire logic [io_map_pkg::ROUTE_COUNT-1:0][1:0] i_analog_route_params,
   input wire logic [io_map_pkg::ROUTE_COUNT-1:0][15:0] o_settings,
   input wire logic o_seq_in7,
   input wire io_map_pkg::pulse_in_cfg_type i_pulse_cfg,
   input wire logic [15:0] o_speed_pulse,
   input wire logic [15:0] o_torque_pulse,
   input wire logic o_pulse_off,
   input wire io_map_pkg::analog_out_cfg_type i_out_first_cfg,
   input wire logic [9:0] o_analog_out_first,
   input wire logic o_out_first_current,
   input wire io_map_pkg::pulse_out_cfg_type i_pulse_out_cfg,
   input wire logic i_seq_out3,
   input wire logic o_pulse_output_terminal,
   input wire logic o_encoder_division_block
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Any destination on pulse code claims terminal seven
   wire pulse_used = (i_pulse_cfg.speed_source_select == 3'h5)
      || (i_pulse_cfg.traverse_source_select == 3'h5)
      || (i_pulse_cfg.torque_source_select == 3'h5);
   wire first_full = !i_analog_in.first_half;
   wire [1:0] out_mode = i_out_first_cfg.range_mode;
   // Input routing and output ranges
   property p_seq_in7; pulse_used |-> !o_seq_in7; endproperty
   a_seq_in7: assert property (p_seq_in7) else $error("terminal seven not blocked");
   property p_route_first;
      i_analog_route_params[0] == 2'h1 && first_full |=>
         o_settings[0] == {4'h0, $past(i_analog_in.first)};
   endproperty
   a_route_first: assert property (p_route_first) else $error("route mismatch");
   property p_route_none; i_analog_route_params[1] == 2'h0 |=> o_settings[1] == 16'h0; endproperty
   a_route_none: assert property (p_route_none) else $error("unrouted not zero");
   property p_torque_x3;
      i_analog_route_params[6] == 2'h1 && first_full |=>
         o_settings[6] == {4'h0, $past(i_analog_in.first)} * 16'h0003;
   endproperty
   a_torque_x3: assert property (p_torque_x3) else $error("torque not tripled");
   property p_speed_cap; o_speed_pulse <= 16'h1000; endproperty
   a_speed_cap: assert property (p_speed_cap) else $error("speed above span");
   property p_torque_cap; o_torque_pulse <= 16'h3000; endproperty
   a_torque_cap: assert property (p_torque_cap) else $error("torque above span");
   property p_lost; o_pulse_off && $past(o_pulse_off) |-> o_speed_pulse == 16'h0; endproperty
   a_lost: assert property (p_lost) else $error("lost input not zero");
   property p_cur_flag; out_mode == 2'h3 |=> o_out_first_current; endproperty
   a_cur_flag: assert property (p_cur_flag) else $error("current flag low");
   property p_bad_mode; out_mode != 2'h1 && out_mode != 2'h3 |=> o_analog_out_first == 10'h0;
   endproperty
   a_bad_mode: assert property (p_bad_mode) else $error("undefined mode drives");
   property p_pass; i_pulse_out_cfg.enable != 2'h1 |-> o_pulse_output_terminal == i_seq_out3;
   endproperty
   a_pass: assert property (p_pass) else $error("terminal three not ordinary");
   property p_div_block; o_encoder_division_block == (i_pulse_out_cfg.enable == 2'h1); endproperty
   a_div_block: assert property (p_div_block) else $error("division block wrong");
   // Main scenarios reached
   c_speed_full: cover property (o_speed_pulse == 16'h1000);
   c_regain: cover property ($fell(o_pulse_off));
   c_pulse_fall: cover property (o_encoder_division_block && $fell(o_pulse_output_terminal));
endmodule

//--- dv/io_far_side.sv
// Purpose: External pulse source and pulse receiver
// Assumes: Half period given in clock cycles, below 2 means stopped
// Notes: Source rests low between trains
`timescale 1ns/1ps
module io_far_side (
   input wire logic i_clk,
   input wire logic [15:0] i_half,
   input wire logic i_rx,
   output logic o_pin,
   output int o_falls,
   output int o_period
);
   int cnt = 0;
   int since = 0;
   logic rx_d = 1'b0;
   initial o_pin = 1'b0;
   initial o_falls = 0;
   initial o_period = 0;
   // Square wave, at least two cycles per level keeps it in range
   always @(posedge i_clk)
      if (i_half < 16'h2)
         o_pin <= 1'b0;
      else if (cnt + 1 >= int'(i_half))
      begin
         o_pin <= !o_pin;
         cnt <= 0;
      end
      else
         cnt <= cnt + 1;
   // Receiver counts falling edges and the cycles between them
   always @(posedge i_clk)
   begin
      rx_d <= i_rx;
      since <= since + 1;
      if (rx_d && !i_rx)
      begin
         o_falls <= o_falls + 1;
         o_period <= since + 1;
         since <= 0;
      end
   end
endmodule

//--- dv/test_pulse_train_and_analog_io_map.sv
// Purpose: Self-checking bench for the pulse-train and analog I/O map
// Assumes: Gate shortened to 1000 cycles and the millisecond tick to 10
// Notes: Pulse frequencies are scaled by the short gate, ten hertz per edge
`timescale 1ns/1ps
module test_pulse_train_and_analog_io_map;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   io_map_pkg::analog_in_type ain = '0;
   logic [10:0][1:0] rt = '0;
   io_map_pkg::pulse_in_cfg_type pc = '0;
   logic [15:0][15:0] idat = '0;
   io_map_pkg::analog_out_cfg_type oc = '0;
   io_map_pkg::pulse_out_cfg_type po = '0;
   logic seq3 = 1'b0;
   logic [15:0] half = '0;
   logic pin, seq7, poff, cur1, cur2, pout, blk;
   logic [10:0][15:0] st;
   logic [15:0] sp, tv, tq;
   logic [9:0] ao1, ao2;
   int falls, per;
   int fail_count = 0;
   int n_compared = 0;
   always #5 clk = ~clk;
   pulse_train_and_analog_io_map #(.GATE_LEN(1000), .MS_LEN(10)) dut (.i_clk(clk),
      .i_reset_n(rst_n), .i_analog_in(ain), .i_analog_route_params(rt), .o_settings(st),
      .i_pulse_input_terminal(pin), .o_seq_in7(seq7), .i_pulse_cfg(pc), .o_speed_pulse(sp),
      .o_traverse_pulse(tv), .o_torque_pulse(tq), .o_pulse_off(poff), .i_internal_data(idat),
      .i_out_first_cfg(oc), .i_out_second_cfg(oc), .o_analog_out_first(ao1),
      .o_analog_out_second(ao2), .o_out_first_current(cur1), .o_out_second_current(cur2),
      .i_pulse_out_cfg(po), .i_seq_out3(seq3), .o_pulse_output_terminal(pout),
      .o_encoder_division_block(blk));
   io_far_side far (.i_clk(clk), .i_half(half), .i_rx(pout), .o_pin(pin), .o_falls(falls),
      .o_period(per));
   task automatic test_done;
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_falls(input int n);
      int f0;
      f0 = falls;
      for (int i = 0; i < 30000 && falls < f0 + n; i++)
         tick(1);
      if (falls < f0 + n)
      begin
         fail_count++;
         test_done();
      end
   endtask
   task automatic route_case;
      @(posedge clk);
      ain <= '{12'h800, 12'h123, -12'sh100, 1'b0, 1'b0};
      rt <= '{6: 2'h1, 3: 2'h3, 2: 2'h2, 0: 2'h1, default: 2'h0};
      tick(2);
      chk(st[0], 16'h0800);
      chk(st[1], 16'h0000);
      chk(st[2], 16'h0123);
      chk(st[3], 16'hfe00);
      chk(st[6], 16'h1800);
      // Half range on the first channel drops the top bit and doubles the code
      @(posedge clk);
      ain.first_half <= 1'b1;
      tick(2);
      chk(st[0], 16'h0000);
   endtask
   task automatic aout(input logic [1:0] m, input logic [15:0] d, input logic [10:0] vo,
                       input logic [9:0] e);
      @(posedge clk);
      idat[1] <= d;
      oc <= '{m, 4'h1, 10'h200, vo, 11'h0};
      tick(2);
      chk(16'(ao1), 16'(e));
      chk(16'(ao2), 16'(e));
      chk(16'({cur1, cur2}), (m == 2'h3) ? 16'h3 : 16'h0);
   endtask
   task automatic bypass;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         po <= '{2'h2, 4'h2, 14'd5000, 14'd5000, 2'h2};
         seq3 <= i[0];
         tick(1);
         chk(16'({pout, blk}), 16'({i[0], 1'b0}));
      end
   endtask
   task automatic pin_case(input int dest, input logic [15:0] h, input logic [2:0] k,
                           input int lo, input int hi);
      logic [15:0] v;
      @(posedge clk);
      pc <= '{(dest == 0) ? 3'h5 : 3'h0, (dest == 1) ? 3'h5 : 3'h0, (dest == 2) ? 3'h5 : 3'h0,
              14'd100, 14'd1100, k, 16'd30};
      half <= h;
      tick(3500);
      v = (dest == 0) ? sp : (dest == 1) ? tv : tq;
      chk(16'(v >= lo && v <= hi), 16'h1);
      // Look at the sequence input while the pin is high
      if (!pin)
         tick(int'(h));
      chk(16'(seq7), 16'h0);
   endtask
   task automatic loss_case;
      @(posedge clk);
      half <= '0;
      for (int i = 0; i < 2000 && poff !== 1'b1; i++)
         tick(1);
      tick(2);
      chk(16'(poff), 16'h1);
      chk(sp, 16'h0);
      if (poff !== 1'b1)
         test_done();
   endtask
   task automatic pulse_out(input logic [15:0] d, input logic [1:0] mag, input logic run);
      int f0;
      @(posedge clk);
      idat[2] <= d;
      po <= '{2'h1, 4'h2, 14'd5000, 14'd5000, mag};
      seq3 <= 1'b0;
      tick(100);
      chk(16'(blk), 16'h1);
      if (run)
      begin
         wait_falls(2);
         chk(16'(per >= 9999 && per <= 10001), 16'h1);
      end
      else
      begin
         f0 = falls;
         tick(12000);
         chk(16'(falls - f0), 16'h0);
      end
   endtask
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      route_case();
      aout(2'h1, 16'h0400, 11'h0, 10'd512);
      aout(2'h3, 16'h0400, 11'h0, 10'd614);
      aout(2'h0, 16'h0400, 11'h0, 10'd0);
      aout(2'h1, 16'hfc00, 11'd600, 10'd88);
      bypass();
      pin_case(0, 16'h2, 3'h0, 4096, 4096);
      loss_case();
      pin_case(2, 16'h2, 3'h0, 12288, 12288);
      pin_case(1, 16'ha, 3'h0, 1597, 1679);
      pin_case(0, 16'h64, 3'h0, 0, 0);
      pin_case(0, 16'h2, 3'h3, 1, 4095);
      pulse_out(16'h7fff, 2'h2, 1'b1);
      pulse_out(16'h8000, 2'h2, 1'b0);
      pulse_out(16'h8000, 2'h1, 1'b1);
      test_done();
   end
endmodule
bind pulse_train_and_analog_io_map io_map_chk u_chk (.i_clk, .i_reset_n, .i_analog_in,
   .i_analog_route_params, .o_settings, .o_seq_in7, .i_pulse_cfg, .o_speed_pulse,
   .o_torque_pulse, .o_pulse_off, .i_out_first_cfg, .o_analog_out_first, .o_out_first_current,
   .i_pulse_out_cfg, .i_seq_out3, .o_pulse_output_terminal, .o_encoder_division_block);
